// *** design/sebs_pkg.sv ***
// Shared constants, types and states for the serial EEPROM bus target
package sebs_pkg;

    // Array geometry
    localparam int SEBS_ADDR_W = 14;
    localparam int SEBS_DATA_W = 8;
    localparam int SEBS_PAGE_W = 6;
    localparam int SEBS_PAGE_BYTES = 64;

    // Device address word fields
    localparam int SEBS_TYPE_MSB = 7;
    localparam int SEBS_TYPE_LSB = 4;
    localparam int SEBS_SEL_MSB = 3;
    localparam int SEBS_SEL_LSB = 1;
    localparam int SEBS_DIR_BIT = 0;
    localparam logic SEBS_DIR_READ = 1'h1;

    // Arbitrary neutral device-type code
    localparam logic [3:0] SEBS_TYPE_CODE = 4'h6;

    // Bit counting within a word
    localparam logic [3:0] SEBS_LAST_BIT = 4'h7;
    localparam logic [3:0] SEBS_ACK_SLOT = 4'h8;

    // Internal write cycle time, longest, rounded down to whole cycles
    localparam int SEBS_WC_TIME_US = 5000;
    localparam int SEBS_CORE_CLK_MHZ = 100;
    localparam int SEBS_WC_CYCLES = SEBS_WC_TIME_US * SEBS_CORE_CLK_MHZ;

    // Pins that are sampled into the core domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic [2:0] sel;
    } sebs_pins_s;

    // Transaction states
    typedef enum logic [6:0] {
        SEBS_IDLE = 7'h01,
        SEBS_DEVA = 7'h02,
        SEBS_AHI  = 7'h04,
        SEBS_ALO  = 7'h08,
        SEBS_WDAT = 7'h10,
        SEBS_RSTA = 7'h20,
        SEBS_RDAT = 7'h40
    } sebs_state_e;

endpackage : sebs_pkg

// *** design/sebs_top.sv ***
// Two-wire bus target front end with 16K x 8 array and timed page write
`timescale 1ns/1ps

// How it works
// - Input bits are caught on bus clock rise; output changes after bus clock fall.
// - Data line is only pulled low or released, never driven high.
// - Data changes only while bus clock is low, except start and stop.
// - Data falling while bus clock high is a start; it opens every transaction.
// - Data rising while bus clock high is a stop; a read ends in standby.
// - A stop after write data launches the timed write, then standby.
// - Words are 8 bits; the sender releases on the ninth clock, receiver acks low.
// - Each written word is acked low unless protected or not addressed.
// - Reads ack the address word, release after each byte, continue on low ack.
// - A high ack then stop ends the read and returns to standby.
// - Without low ack or stop, the line stays released and no data is sent.
// - Address word: 4-bit type code, 3-bit select code, direction bit.
// - Select code arrives MSB first, must equal select pins 2, 1, 0.
// - Direction 0 starts a write, direction 1 starts a read.
// - Matching word is acked low; any mismatch gets no ack and standby.
// - Protect pin high: address bytes acked, data bytes refused, nothing written.
// - Protect pin low allows all writes; reads ignore the protect pin.
// - Byte write: address word, two address bytes, one data byte, all acked.
// - During the timed write the bus is ignored; standby once it ends.
// - Timed write lasts at most 5 ms from the stop.
// - Extra data bytes form a 64-byte page; low six address bits wrap.
// - Write-direction word during the timed write is refused, acked after.
// - Address counter holds last address plus one for current-address reads.
module sebs_top
    import sebs_pkg::*;
#(
    parameter int unsigned WC_CYCLES = SEBS_WC_CYCLES,
    // Arbitrary value, not any maker's code
    parameter logic [3:0] TYPE_CODE = SEBS_TYPE_CODE
)
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Two-wire bus
    input wire logic bus_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and protection
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic write_protect,
    // Status
    output logic write_busy
);

    localparam int AW = SEBS_ADDR_W;
    localparam int DW = SEBS_DATA_W;
    localparam int PW = SEBS_PAGE_W;

    // Link domain: bit capture and line drive
    logic rx_bit_q;
    logic rise_tgl_q;
    logic drive_q;
    logic drive_next_q;
    logic drive_next_d;

    always_ff @(posedge bus_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_bit_q <= 1'h0;
            rise_tgl_q <= 1'h0;
        end
        else
        begin
            rx_bit_q <= sda_in;
            rise_tgl_q <= ~rise_tgl_q;
        end
    end

    // Core settles the next drive during the high phase, long before the fall
    always_ff @(negedge bus_clk or negedge reset_n)
    begin
        if (!reset_n)
            drive_q <= 1'h0;
        else
            drive_q <= drive_next_q;
    end

    // Open-drain: only low or released
    assign sda_out = 1'h0;
    assign sda_oe = drive_q;

    // Core domain synchronisers
    sebs_pins_s pins_raw;
    sebs_pins_s pins_s1_q;
    sebs_pins_s pins_s2_q;
    sebs_pins_s pins_s3_q;
    logic [2:0] tgl_sync_q;

    // Floating straps are expected to arrive as low
    assign pins_raw = '{scl: bus_clk, sda: sda_in, wp: write_protect,
                        sel: {select_pin_bit2, select_pin_bit1, select_pin_bit0}};

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins_s1_q <= '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};
            pins_s2_q <= '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};
            pins_s3_q <= '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};
            tgl_sync_q <= 3'h0;
        end
        else
        begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
            pins_s3_q <= pins_s2_q;
            tgl_sync_q <= {tgl_sync_q[1:0], rise_tgl_q};
        end
    end

    // Bus events
    wire scl_high = pins_s2_q.scl & pins_s3_q.scl;
    wire start_evt = scl_high & pins_s3_q.sda & ~pins_s2_q.sda;
    wire stop_evt = scl_high & ~pins_s3_q.sda & pins_s2_q.sda;
    wire rise_evt = tgl_sync_q[2] ^ tgl_sync_q[1];
    // Stable from the rise until the next rise, so the core reads it directly
    wire bit_in = rx_bit_q;

    // Transaction state
    sebs_state_e state_q;
    sebs_state_e state_d;
    logic [3:0] bit_cnt_q;
    logic [DW-1:0] shift_q;
    logic [DW-1:0] tx_q;
    logic [PW-1:0] ahi_q;
    logic [AW-1:0] addr_cnt_q;
    logic [AW-PW-1:0] page_q;
    logic [SEBS_PAGE_BYTES-1:0] pvalid_q;
    logic busy_q;
    logic [31:0] wc_cnt_q;

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] pbuf [0:SEBS_PAGE_BYTES-1];

    // Word decode
    wire byte_done = rise_evt & (bit_cnt_q == SEBS_LAST_BIT);
    wire ack_slot = rise_evt & (bit_cnt_q == SEBS_ACK_SLOT);
    wire [DW-1:0] new_byte = {shift_q[DW-2:0], bit_in};
    wire type_ok = new_byte[SEBS_TYPE_MSB:SEBS_TYPE_LSB] == TYPE_CODE;
    wire sel_ok = new_byte[SEBS_SEL_MSB:SEBS_SEL_LSB] == pins_s2_q.sel;
    wire dir_rd = new_byte[SEBS_DIR_BIT] == SEBS_DIR_READ;
    wire dev_ok = type_ok & sel_ok & ~busy_q;
    wire wp_on = pins_s2_q.wp;
    wire in_rx = (state_q == SEBS_DEVA) | (state_q == SEBS_AHI) | (state_q == SEBS_ALO) | (state_q == SEBS_WDAT);
    wire data_ok = (state_q == SEBS_WDAT) & ~wp_on;
    wire ack_ok = ((state_q == SEBS_DEVA) & dev_ok) | (state_q == SEBS_AHI) | (state_q == SEBS_ALO) | data_ok;
    wire load_rd = ack_slot & ((state_q == SEBS_RSTA) | ((state_q == SEBS_RDAT) & ~bit_in));
    wire [DW-1:0] mem_rd = mem[addr_cnt_q];
    wire wr_take = byte_done & data_ok;
    wire wc_launch = stop_evt & (state_q == SEBS_WDAT) & (|pvalid_q) & ~busy_q;
    wire wc_done = busy_q & (wc_cnt_q == WC_CYCLES - 1);
    wire [PW-1:0] commit_idx = wc_cnt_q[PW-1:0];
    wire commit_en = busy_q & (wc_cnt_q < SEBS_PAGE_BYTES) & pvalid_q[commit_idx];

    // Next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SEBS_IDLE:
                state_d = SEBS_IDLE;
            SEBS_DEVA:
                if (byte_done)
                    state_d = !dev_ok ? SEBS_IDLE : (dir_rd ? SEBS_RSTA : SEBS_AHI);
            SEBS_AHI:
                if (byte_done)
                    state_d = SEBS_ALO;
            SEBS_ALO:
                if (byte_done)
                    state_d = SEBS_WDAT;
            SEBS_WDAT:
                state_d = SEBS_WDAT;
            SEBS_RSTA:
                if (ack_slot)
                    state_d = SEBS_RDAT;
            SEBS_RDAT:
                if (ack_slot && bit_in)
                    state_d = SEBS_IDLE;
            default:
                state_d = SEBS_IDLE;
        endcase
        if (stop_evt)
            state_d = SEBS_IDLE;
        if (start_evt)
            state_d = SEBS_DEVA;
    end

    // Next line drive, settled in the high phase for the coming low phase
    always_comb
    begin
        drive_next_d = drive_next_q;
        if (start_evt || stop_evt)
            drive_next_d = 1'h0;
        else if (byte_done)
            drive_next_d = in_rx & ack_ok;
        else if (ack_slot)
            drive_next_d = load_rd & ~mem_rd[DW-1];
        else if (rise_evt && state_q == SEBS_RDAT && bit_cnt_q < SEBS_LAST_BIT)
            drive_next_d = ~tx_q[DW-2];
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= SEBS_IDLE;
            drive_next_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            drive_next_q <= drive_next_d;
        end
    end

    // Bit counter and shifters
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
        end
        else
        begin
            if (start_evt)
                bit_cnt_q <= 4'h0;
            else if (rise_evt)
                bit_cnt_q <= (bit_cnt_q == SEBS_ACK_SLOT) ? 4'h0 : bit_cnt_q + 4'h1;
            if (rise_evt && bit_cnt_q < SEBS_ACK_SLOT)
                shift_q <= new_byte;
            if (load_rd)
                tx_q <= mem_rd;
            else if (rise_evt && state_q == SEBS_RDAT && bit_cnt_q < SEBS_LAST_BIT)
                tx_q <= {tx_q[DW-2:0], 1'h0};
        end
    end

    // Address counter, page buffer flags and write cycle timer
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ahi_q <= 6'h00;
            addr_cnt_q <= 14'h0000;
            page_q <= 8'h00;
            pvalid_q <= 64'h0;
            busy_q <= 1'h0;
            wc_cnt_q <= 32'h0;
        end
        else
        begin
            if (byte_done && state_q == SEBS_AHI)
                ahi_q <= new_byte[PW-1:0];
            if (byte_done && state_q == SEBS_ALO)
                addr_cnt_q <= {ahi_q, new_byte};
            else if (wr_take)
                addr_cnt_q[PW-1:0] <= addr_cnt_q[PW-1:0] + 6'h01;
            else if (load_rd)
                addr_cnt_q <= addr_cnt_q + 14'h0001;
            if (wr_take)
                page_q <= addr_cnt_q[AW-1:PW];
            if (wc_launch)
            begin
                busy_q <= 1'h1;
                wc_cnt_q <= 32'h0;
            end
            else if (wc_done)
            begin
                busy_q <= 1'h0;
                pvalid_q <= 64'h0;
            end
            else if (busy_q)
                wc_cnt_q <= wc_cnt_q + 32'h1;
            else if (start_evt)
                pvalid_q <= 64'h0;
            else if (wr_take)
                pvalid_q[addr_cnt_q[PW-1:0]] <= 1'h1;
        end
    end

    // Storage: page buffer filled on the bus, array written during the timed cycle
    always_ff @(posedge core_clk)
    begin
        if (wr_take)
            pbuf[addr_cnt_q[PW-1:0]] <= new_byte;
        if (commit_en)
            mem[{page_q, commit_idx}] <= pbuf[commit_idx];
    end

    assign write_busy = busy_q;

    // Checks
    a_start_resets: assert property (@(posedge core_clk) disable iff (!reset_n)
        start_evt |=> (bit_cnt_q == 4'h0) && (state_q == SEBS_DEVA))
        else $error("start did not open a new address word");

    a_read_stop_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (stop_evt && !start_evt && (state_q == SEBS_RDAT)) |=> (state_q == SEBS_IDLE) && !drive_next_q)
        else $error("stop did not return a read to standby");

    a_stop_standby: assert property (@(posedge core_clk) disable iff (!reset_n)
        (stop_evt && !start_evt) |=> (state_q == SEBS_IDLE))
        else $error("stop did not return to standby");

    a_match_ack: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && !start_evt && !stop_evt && (state_q == SEBS_DEVA) && type_ok && sel_ok && !busy_q)
        |=> drive_next_q)
        else $error("matching address word not acknowledged");

    a_mismatch_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && !start_evt && !stop_evt && (state_q == SEBS_DEVA) && !(type_ok && sel_ok))
        |=> (state_q == SEBS_IDLE) && !drive_next_q)
        else $error("mismatched address word not refused");

    a_dir_select: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && !start_evt && !stop_evt && (state_q == SEBS_DEVA) && dev_ok)
        |=> ((state_q == SEBS_RSTA) == $past(dir_rd)) && (state_q != SEBS_IDLE))
        else $error("direction bit chose the wrong operation");

    a_busy_refuse: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && (state_q == SEBS_DEVA) && busy_q) |=> !drive_next_q && (state_q != SEBS_AHI))
        else $error("address word acknowledged during write cycle");

    a_busy_no_take: assert property (@(posedge core_clk) disable iff (!reset_n)
        busy_q |-> !wr_take && (state_q != SEBS_WDAT))
        else $error("bus data taken during write cycle");

    a_protect_refuse: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && (state_q == SEBS_WDAT) && wp_on) |=> !drive_next_q && ($stable(pvalid_q) || !busy_q))
        else $error("protected data byte acknowledged");

    a_addr_bytes_ack: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && !start_evt && !stop_evt && ((state_q == SEBS_AHI) || (state_q == SEBS_ALO)))
        |=> drive_next_q)
        else $error("memory address byte not acknowledged");

    a_release_tx: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_done && (state_q == SEBS_RDAT)) |=> !drive_next_q)
        else $error("line not released after a read byte");

    a_read_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        (load_rd && !start_evt && !stop_evt)
        |=> (tx_q == $past(mem_rd)) && (addr_cnt_q == $past(addr_cnt_q) + 14'h0001))
        else $error("read byte not loaded from the address counter");

    a_nack_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ack_slot && !start_evt && (state_q == SEBS_RDAT) && bit_in) |=> !drive_next_q && $stable(tx_q))
        else $error("data sent after a missing acknowledge");

    a_page_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_take |=> (addr_cnt_q[AW-1:PW] == $past(addr_cnt_q[AW-1:PW])))
        else $error("page write left its page");

    a_wc_launch: assert property (@(posedge core_clk) disable iff (!reset_n)
        wc_launch |=> busy_q && (wc_cnt_q == 32'h0))
        else $error("stop after data did not start write cycle");

    a_wc_end: assert property (@(posedge core_clk) disable iff (!reset_n)
        wc_done |=> !busy_q && (pvalid_q == 64'h0))
        else $error("write cycle did not end in standby");

    a_wc_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
        busy_q |-> (wc_cnt_q < WC_CYCLES))
        else $error("write cycle overran its time");

endmodule : sebs_top

// *** test/sebs_bus_ctrl.sv ***
// Two-wire bus controller model driving the bus clock and pulling the data line
`timescale 1ns/1ps
module sebs_bus_ctrl
(
    // Bus side
    output logic scl,
    output logic ctrl_oe,
    input wire logic sda_line
);
    // Half the low phase; 1300 ns low and 1200 ns high keep the clock at 400 kHz
    localparam int T_Q = 650;

    initial
    begin
        scl = 1'b1;
        ctrl_oe = 1'b0;
    end

    // Data moves only in mid low phase; clock idles high between frames
    task automatic clk_bit(input logic b, output logic r);
        #T_Q ctrl_oe = ~b;
        #T_Q scl = 1'b1;
        #600 r = sda_line;
        #600 scl = 1'b0;
    endtask : clk_bit

    task automatic start_c();
        if (!scl)
        begin
            #T_Q ctrl_oe = 1'b0;
            #T_Q scl = 1'b1;
        end
        #T_Q ctrl_oe = 1'b1;
        #T_Q scl = 1'b0;
    endtask : start_c

    task automatic stop_c();
        #T_Q ctrl_oe = 1'b1;
        #T_Q scl = 1'b1;
        #T_Q ctrl_oe = 1'b0;
        #1300;
    endtask : stop_c

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, ack);
    endtask : send_byte

    // Line released while the device sends; ack bit given in the ninth slot
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(ack, r);
    endtask : recv_byte
endmodule : sebs_bus_ctrl

// *** test/tb_serial_eeprom_bus_slave.sv ***
// Self-checking bench for the serial EEPROM bus target
`timescale 1ns/1ps
module tb_serial_eeprom_bus_slave
    import sebs_pkg::*;
();
    // Short write cycle so polling fits inside it
    localparam int WC = 4000;
    typedef struct packed {logic [7:0] word; logic rd; logic ack;} sebs_row_s;
    logic core_clk;
    logic reset_n;
    logic wp;
    logic scl;
    logic ctrl_oe;
    logic dut_oe;
    logic dut_out;
    logic busy;
    logic ack;
    logic [7:0] rd;
    wire logic sda_line;
    int errors = 0;
    int n_tests = 0;
    int busy_cnt = 0;
    int busy_base = 0;
    sebs_row_s rows [6];
    logic [7:0] pg [3] = '{8'ha5, 8'h3c, 8'hd2};

    // Pull-up: high unless someone pulls low
    assign sda_line = (dut_oe ? dut_out : 1'b1) & ~ctrl_oe;

    // Bus clock held at its 400 kHz ceiling, not faster, as the core needs long high phases
    sebs_bus_ctrl u_ctrl (.scl(scl), .ctrl_oe(ctrl_oe), .sda_line(sda_line));
    sebs_top #(.WC_CYCLES(WC), .TYPE_CODE(SEBS_TYPE_CODE)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .bus_clk(scl), .sda_in(sda_line), .sda_out(dut_out), .sda_oe(dut_oe), .select_pin_bit0(1'b1),
        .select_pin_bit1(1'b0), .select_pin_bit2(1'b1), .write_protect(wp), .write_busy(busy));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(negedge core_clk)
    begin
        busy_cnt <= busy_cnt + ((busy === 1'b1) ? 1 : 0);
    end

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    function automatic logic [7:0] dev(input logic rd_dir);
        return {SEBS_TYPE_CODE, 3'h5, rd_dir};
    endfunction : dev

    task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
        u_ctrl.start_c();
        u_ctrl.send_byte(dev(1'b0), ack);
        chk_bit(ack, 1'b0);
        u_ctrl.send_byte(hi, ack);
        chk_bit(ack, 1'b0);
        u_ctrl.send_byte(lo, ack);
        chk_bit(ack, 1'b0);
    endtask : set_addr

    // Repeated start into a read
    task automatic rd_open();
        u_ctrl.start_c();
        u_ctrl.send_byte(dev(1'b1), ack);
        chk_bit(ack, 1'b0);
    endtask : rd_open

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2 * WC)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 2 * WC)
        begin
            errors++;
            print_verdict();
        end
    endtask : wait_idle

    initial
    begin
        repeat (100000) @(posedge core_clk);
        errors++;
        print_verdict();
    end

    initial
    begin
        rows[0] = '{dev(1'b1), 1'b1, 1'b0};
        rows[1] = '{{SEBS_TYPE_CODE ^ 4'h8, 3'h5, 1'h0}, 1'b0, 1'b1};
        rows[2] = '{{SEBS_TYPE_CODE, 3'h1, 1'h0}, 1'b0, 1'b1};
        rows[3] = '{{SEBS_TYPE_CODE, 3'h7, 1'h1}, 1'b0, 1'b1};
        rows[4] = '{{SEBS_TYPE_CODE, 3'h4, 1'h0}, 1'b0, 1'b1};
        rows[5] = '{dev(1'b0), 1'b0, 1'b0};
        reset_n = 1'b0;
        wp = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_bit(dut_oe, 1'b0);
        chk_bit(busy, 1'b0);
        reset_n = 1'b1;
        repeat (5) @(negedge core_clk);
        $display("test reset done");
        foreach (rows[i])
        begin
            u_ctrl.start_c();
            u_ctrl.send_byte(rows[i].word, ack);
            chk_bit(ack, rows[i].ack);
            if (rows[i].rd)
            begin
                u_ctrl.recv_byte(1'b1, rd);
            end
            u_ctrl.stop_c();
        end
        wait_idle();
        $display("test address rows done");
        // Page write across the page end; top bits of the high byte are junk
        set_addr(8'hff, 8'h3e);
        foreach (pg[i])
        begin
            u_ctrl.send_byte(pg[i], ack);
            chk_bit(ack, 1'b0);
        end
        busy_base = busy_cnt;
        u_ctrl.stop_c();
        chk_bit(busy, 1'b1);
        u_ctrl.start_c();
        u_ctrl.send_byte(dev(1'b0), ack);
        chk_bit(ack, 1'b1);
        u_ctrl.stop_c();
        wait_idle();
        chk_bit((busy_cnt - busy_base) <= WC, 1'b1);
        set_addr(8'h7f, 8'h3e);
        rd_open();
        u_ctrl.recv_byte(1'b0, rd);
        chk_byte(rd, pg[0]);
        u_ctrl.recv_byte(1'b1, rd);
        chk_byte(rd, pg[1]);
        u_ctrl.stop_c();
        set_addr(8'h3f, 8'h00);
        u_ctrl.stop_c();
        rd_open();
        u_ctrl.recv_byte(1'b1, rd);
        chk_byte(rd, pg[2]);
        u_ctrl.stop_c();
        $display("test page write and reads done");
        @(negedge core_clk);
        wp = 1'b1;
        set_addr(8'h3f, 8'h3e);
        u_ctrl.send_byte(8'h00, ack);
        chk_bit(ack, 1'b1);
        u_ctrl.stop_c();
        chk_bit(busy, 1'b0);
        set_addr(8'h3f, 8'h3e);
        rd_open();
        u_ctrl.recv_byte(1'b1, rd);
        chk_byte(rd, pg[0]);
        u_ctrl.recv_byte(1'b1, rd);
        chk_byte(rd, 8'hff);
        u_ctrl.stop_c();
        $display("test write protect done");
        print_verdict();
    end
endmodule : tb_serial_eeprom_bus_slave
